// ===== cbtg_guard.sv
// balance timeout guard: timer, switch gating, thermal and wake logic
// Functional notes
// - timeout is a 4-bit down counter ticked by a selectable predivider
// - prescale 00 off, 01 one second, 10 four, 11 sixteen seconds
// - timer starts when prescale is written to a non-off setting
// - enabled counter decrements once per tick until it reaches zero
// - reaching zero forces switches off until disabled or nonzero rewrite
// - timeout gates switches separately, switch config stays unchanged
// - count is read/write; reads return value captured at capture strobe
// - enabling with count already zero does not force switches off
// - count and prescale live in upper byte of acquisition config
// - overtemperature disables regulator and forces switches off
// - regulator stays off until die cooled by the hysteresis
// - power-on reset returns all registers to defaults
// - reset flag set when logic wakes; host checks and clears it
// - logic becomes active a fixed delay after oscillator starts
// - switch config holds one enable bit per balancing switch
`timescale 1ns/1ps
module cbtg_guard #(
   parameter int SEC_CYCLES = cbtg_pkg::TICK_CYCLES,
   parameter int WAKE_CYC = cbtg_pkg::WAKE_CYCLES
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic osc_running_i,
   input wire cbtg_pkg::cbtg_req_t req_i,
   input wire logic over_temp_i,
   input wire logic temp_cooled_i,
   output logic [15:0] reg_rdata_o,
   output logic [cbtg_pkg::NUM_SWITCHES-1:0] switch_en_o,
   output logic regulator_en_o,
   output logic logic_active_o
);
   import cbtg_pkg::*;

   cbtg_state_t st;
   cbtg_state_t next_st;
   logic tick;
   logic active;
   logic acq_wr;
   logic bal_wr;
   logic status_wr;
   logic [3:0] wr_count;
   logic [1:0] wr_pre;
   logic gate_ok;
   logic [15:0] read_word;

   // ==========================================================
   // request decode
   assign active = (st.wake == WAKE_ACTIVE);
   assign acq_wr = active && req_i.wr && (req_i.addr == ADDR_ACQ_CFG);
   assign bal_wr = active && req_i.wr && (req_i.addr == ADDR_BAL_CFG);
   assign status_wr = active && req_i.wr && (req_i.addr == ADDR_STATUS);
   assign wr_count = req_i.wdata[ACQ_COUNT_LSB +: 4];
   assign wr_pre = req_i.wdata[ACQ_PRESCALE_LSB +: 2];

   // ==========================================================
   // prescaler
   cbtg_tick #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .restart_i(acq_wr),
      .prescale_i(st.prescale),
      .tick_o(tick)
   );

   // ==========================================================
   // read mux
   always_comb begin
      read_word = 16'h0000;
      case (req_i.addr)
         ADDR_STATUS: begin
            read_word[STATUS_RST_BIT] = st.rst_flag;
            read_word[STATUS_THERM_BIT] = ~st.reg_on;
         end
         ADDR_BAL_CFG: begin
            read_word[NUM_SWITCHES-1:0] = st.bal_cfg;
         end
         ADDR_ACQ_CFG: begin
            read_word[ACQ_LOW_LSB +: 8] = st.acq_low;
            read_word[ACQ_COUNT_LSB +: 4] = st.count;
            read_word[ACQ_PRESCALE_LSB +: 2] = st.prescale;
         end
         default: begin
            read_word = 16'h0000;
         end
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      gate_ok = 1'b0;

      // status write-one-to-clear, wake set applied after so it wins
      if (status_wr && req_i.wdata[STATUS_RST_BIT]) begin
         next_st.rst_flag = 1'b0;
      end

      // wake sequence after power-on reset
      case (st.wake)
         WAKE_OSC: begin
            if (osc_running_i) begin
               next_st.wake = WAKE_DELAY;
               next_st.wake_cnt = 32'h0;
            end
         end
         WAKE_DELAY: begin
            if (st.wake_cnt == 32'(WAKE_CYC - 1)) begin
               next_st.wake = WAKE_ACTIVE;
               next_st.rst_flag = 1'b1;
            end else begin
               next_st.wake_cnt = st.wake_cnt + 32'h1;
            end
         end
         WAKE_ACTIVE: begin
            next_st.wake = WAKE_ACTIVE;
         end
         default: begin
            next_st.wake = WAKE_OSC;
         end
      endcase

      // thermal shutdown with hysteresis
      if (over_temp_i) begin
         next_st.reg_on = 1'b0;
      end else if (!st.reg_on && temp_cooled_i) begin
         next_st.reg_on = 1'b1;
      end

      // balance timer
      if (acq_wr) begin
         next_st.acq_low = req_i.wdata[ACQ_LOW_LSB +: 8];
         next_st.count = wr_count;
         next_st.prescale = wr_pre;
         if (wr_pre == PRESCALE_OFF || wr_count != 4'h0) begin
            next_st.timeout = 1'b0;
         end
      end else if (tick && st.prescale != PRESCALE_OFF &&
                   st.count != 4'h0) begin
         next_st.count = st.count - 4'h1;
         if (st.count == 4'h1) begin
            next_st.timeout = 1'b1;
         end
      end

      // switch config, never touched by timeout or thermal
      if (bal_wr) begin
         next_st.bal_cfg = req_i.wdata[NUM_SWITCHES-1:0];
      end

      // gated enables, separate from the config register
      gate_ok = (next_st.wake == WAKE_ACTIVE) && !next_st.timeout &&
                next_st.reg_on && !over_temp_i;
      next_st.sw_en = next_st.bal_cfg & {NUM_SWITCHES{gate_ok}};

      // read capture at the address acknowledge
      if (req_i.capture) begin
         next_st.rdata = read_word;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st.wake <= WAKE_OSC;
         st.wake_cnt <= 32'h0;
         st.rst_flag <= 1'b0;
         st.reg_on <= 1'b1;
         st.timeout <= 1'b0;
         st.count <= COUNT_RST;
         st.prescale <= PRESCALE_RST;
         st.acq_low <= ACQ_LOW_RST;
         st.bal_cfg <= BAL_CFG_RST;
         st.sw_en <= BAL_CFG_RST;
         st.rdata <= RDATA_RST;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign reg_rdata_o = st.rdata;
   assign switch_en_o = st.sw_en;
   assign regulator_en_o = st.reg_on;
   assign logic_active_o = active;

   // ==========================================================
   // checks
   property p_timeout_off;
      @(posedge clock_i) disable iff (!arst_n_i)
      st.timeout |-> switch_en_o == '0;
   endproperty
   a_timeout_off: assert property (p_timeout_off)
      else $error("switch on during timeout");

   property p_cfg_kept;
      @(posedge clock_i) disable iff (!arst_n_i)
      $rose(st.timeout) && !$past(bal_wr) |-> $stable(st.bal_cfg);
   endproperty
   a_cfg_kept: assert property (p_cfg_kept)
      else $error("switch config changed by timeout");

   property p_decrement;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && tick && st.prescale != PRESCALE_OFF && st.count != 4'h0 &&
      !acq_wr |=> st.count == $past(st.count) - 4'h1;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("counter did not decrement on tick");

   property p_zero_enable;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && acq_wr && wr_count == 4'h0 && !st.timeout |=> !st.timeout;
   endproperty
   a_zero_enable: assert property (p_zero_enable)
      else $error("enable at zero forced timeout");

   property p_disable;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && acq_wr && wr_pre == PRESCALE_OFF |=>
      !st.timeout && st.prescale == PRESCALE_OFF;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable did not release timeout");

   property p_start;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && acq_wr && wr_pre != PRESCALE_OFF |=>
      st.prescale == $past(wr_pre) && st.count == $past(wr_count);
   endproperty
   a_start: assert property (p_start)
      else $error("timer not loaded by write");

   property p_thermal;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && over_temp_i |=> !regulator_en_o && switch_en_o == '0;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("overtemperature did not shut down");

   property p_hysteresis;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && !st.reg_on && !temp_cooled_i |=> !st.reg_on;
   endproperty
   a_hysteresis: assert property (p_hysteresis)
      else $error("regulator restarted before cooling");

   property p_wake_gate;
      @(posedge clock_i) disable iff (!arst_n_i)
      !active |-> switch_en_o == '0;
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("switch on before logic active");

   property p_rst_flag;
      @(posedge clock_i) disable iff (!arst_n_i)
      $rose(active) |-> st.rst_flag;
   endproperty
   a_rst_flag: assert property (p_rst_flag)
      else $error("reset flag not set on wake");

   property p_read;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && req_i.capture && req_i.addr == ADDR_ACQ_CFG |=>
      reg_rdata_o[ACQ_COUNT_LSB +: 4] == $past(st.count);
   endproperty
   a_read: assert property (p_read)
      else $error("captured count mismatch");

   property p_count_hold;
      @(posedge clock_i) disable iff (!arst_n_i)
      !(ce_i && (acq_wr || tick)) |=> $stable(st.count);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved without tick or write");

   property p_timeout_rise;
      @(posedge clock_i) disable iff (!arst_n_i)
      $rose(st.timeout) |-> st.count == 4'h0 && $past(st.count) == 4'h1;
   endproperty
   a_timeout_rise: assert property (p_timeout_rise)
      else $error("timeout without count reaching zero");

   property p_flag_clear;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && status_wr && req_i.wdata[STATUS_RST_BIT] |=> !st.rst_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("reset flag not cleared by host");

   property p_cfg_write;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && bal_wr |=>
      st.bal_cfg == $past(req_i.wdata[NUM_SWITCHES-1:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("switch config not written");

endmodule

// ===== cbtg_guard_test.sv
// self-checking bench for the balance timeout guard
`timescale 1ns/1ps
module cbtg_guard_test;
   import cbtg_pkg::*;
   localparam int SEC = 10;
   localparam int WAKE = 5;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic osc_running_i = 1'b0;
   logic over_temp_i = 1'b0;
   logic temp_cooled_i = 1'b0;
   cbtg_req_t req;
   logic [15:0] reg_rdata_o;
   logic [NUM_SWITCHES-1:0] switch_en_o;
   logic regulator_en_o;
   logic logic_active_o;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int per;
   logic [31:0] seed = 32'hee2861cc;
   logic [11:0] cfg;
   logic [15:0] w;

   cbtg_guard #(.SEC_CYCLES(SEC), .WAKE_CYC(WAKE)) u_dut (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .osc_running_i(osc_running_i),
      .req_i(req),
      .over_temp_i(over_temp_i),
      .temp_cooled_i(temp_cooled_i),
      .reg_rdata_o(reg_rdata_o),
      .switch_en_o(switch_en_o),
      .regulator_en_o(regulator_en_o),
      .logic_active_o(logic_active_o)
   );
   cbtg_host u_host (
      .clock_i(clock_i),
      .rdata_i(reg_rdata_o),
      .req_o(req)
   );

   // ==========================================
   // clock and watchdog
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] acq(input logic [1:0] p,
         input logic [3:0] c, input logic [7:0] lo);
      return {2'b00, p, c, lo};
   endfunction
   function automatic int period(input logic [1:0] p);
      return (p == PRESCALE_4S) ? SEC * 4 :
         ((p == PRESCALE_16S) ? SEC * 16 : SEC);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string m);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      u_host.rd(a, d);
      chk(d, e, $sformatf("read %h", a));
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic rst_seq();
      @(posedge clock_i);
      arst_n_i <= 1'b0;
      osc_running_i <= 1'b0;
      cw(10);
      chk({4'h0, switch_en_o}, 16'h0000, "sw in reset");
      chk({15'h0, regulator_en_o}, 16'h0001, "reg in reset");
      @(posedge clock_i);
      arst_n_i <= 1'b1;
      cw(20);
      chk({15'h0, logic_active_o}, 16'h0000, "early active");
      @(posedge clock_i);
      osc_running_i <= 1'b1;
      cw(WAKE);
      chk({15'h0, logic_active_o}, 16'h0000, "wake early");
      cw(1);
      chk({15'h0, logic_active_o}, 16'h0001, "wake");
   endtask

   // ==========================================
   // scenarios
   initial begin
      rst_seq();
      rdchk(ADDR_STATUS, 16'h0001);
      u_host.wr(ADDR_STATUS, 16'h0001); // host clears flag
      rdchk(ADDR_STATUS, 16'h0000);
      rdchk(ADDR_ACQ_CFG, 16'h0000);
      rdchk(8'h33, 16'h0000);
      $display("test reset done");
      u_host.wr(ADDR_ACQ_CFG, 16'hffff);
      rdchk(ADDR_ACQ_CFG, 16'h3fff);
      w = seed[15:0] & 16'h0fff;
      u_host.wr(ADDR_ACQ_CFG, w);
      rdchk(ADDR_ACQ_CFG, w);
      seed = lfsr(seed);
      cfg = seed[11:0] | 12'h001;
      u_host.wr(ADDR_BAL_CFG, {4'h0, cfg});
      rdchk(ADDR_BAL_CFG, {4'h0, cfg});
      cw(2);
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "sw cfg");
      $display("test fields done");
      for (int p = 1; p < 4; p++) begin
         seed = lfsr(seed);
         per = period(p[1:0]);
         u_host.wr(ADDR_ACQ_CFG, acq(p[1:0], 4'h2, seed[7:0]));
         cw(per + 2);
         rdchk(ADDR_ACQ_CFG, acq(p[1:0], 4'h1, seed[7:0]));
         cw(per - 8);
         chk({4'h0, switch_en_o}, {4'h0, cfg}, "sw early");
         cw(5);
         chk({4'h0, switch_en_o}, 16'h0000, "sw timeout");
         rdchk(ADDR_BAL_CFG, {4'h0, cfg});
         rdchk(ADDR_ACQ_CFG, acq(p[1:0], 4'h0, seed[7:0]));
         if (p == 2) begin
            u_host.wr(ADDR_ACQ_CFG, acq(PRESCALE_OFF, 4'h0, 8'h00));
         end else begin
            u_host.wr(ADDR_ACQ_CFG, acq(p[1:0], 4'h5, 8'h00));
         end
         cw(2);
         chk({4'h0, switch_en_o}, {4'h0, cfg}, "sw back");
         u_host.wr(ADDR_ACQ_CFG, 16'h0000);
      end
      $display("test timeout done");
      u_host.wr(ADDR_ACQ_CFG, acq(PRESCALE_1S, 4'h0, 8'h00));
      cw(3 * SEC);
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "zero enable");
      u_host.wr(ADDR_ACQ_CFG, acq(PRESCALE_OFF, 4'h1, 8'h00));
      cw(20 * SEC);
      rdchk(ADDR_ACQ_CFG, acq(PRESCALE_OFF, 4'h1, 8'h00));
      for (int i = 0; i < 5; i++) begin
         u_host.wr(ADDR_ACQ_CFG, acq(PRESCALE_1S, 4'h2, 8'h00));
         cw(SEC);
      end
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "refresh");
      // clock enable low freezes the running timer
      u_host.wr(ADDR_ACQ_CFG, acq(PRESCALE_1S, 4'h1, 8'h00));
      @(posedge clock_i);
      ce_i <= 1'b0;
      cw(3 * SEC);
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "frozen");
      @(posedge clock_i);
      ce_i <= 1'b1;
      cw(SEC - 3);
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "thawed");
      cw(5);
      chk({4'h0, switch_en_o}, 16'h0000, "thaw timeout");
      u_host.wr(ADDR_ACQ_CFG, 16'h0000);
      $display("test modes done");
      @(posedge clock_i);
      over_temp_i <= 1'b1;
      cw(2);
      chk({15'h0, regulator_en_o}, 16'h0000, "reg hot");
      chk({4'h0, switch_en_o}, 16'h0000, "sw hot");
      rdchk(ADDR_STATUS, 16'h0002);
      rdchk(ADDR_BAL_CFG, {4'h0, cfg});
      @(posedge clock_i);
      over_temp_i <= 1'b0;
      cw(3);
      chk({15'h0, regulator_en_o}, 16'h0000, "reg warm");
      @(posedge clock_i);
      temp_cooled_i <= 1'b1;
      cw(3);
      chk({15'h0, regulator_en_o}, 16'h0001, "reg cool");
      chk({4'h0, switch_en_o}, {4'h0, cfg}, "sw cool");
      $display("test thermal done");
      rst_seq();
      rdchk(ADDR_BAL_CFG, 16'h0000);
      rdchk(ADDR_STATUS, 16'h0001);
      $display("test rereset done");
      test_done();
   end
endmodule

// ===== cbtg_host.sv
// host controller model driving the guard register port
`timescale 1ns/1ps
module cbtg_host (
   input wire logic clock_i,
   input wire logic [15:0] rdata_i,
   output cbtg_pkg::cbtg_req_t req_o
);
   import cbtg_pkg::*;
   // ==========================================
   // bus cycles
   initial req_o = '0;
   // whole word, strobe held until its taking edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      req_o <= {1'b1, 1'b0, a, d};
      @(posedge clock_i);
      req_o <= {1'b0, 1'b0, ~a, ~d};
   endtask
   // capture strobe, word taken one edge later
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock_i);
      req_o <= {1'b0, 1'b1, a, 16'h0000};
      @(posedge clock_i);
      req_o <= {1'b0, 1'b0, ~a, 16'hffff};
      @(posedge clock_i);
      #1;
      d = rdata_i;
   endtask
   // no pack switch here, open-cell undervoltage unseen
endmodule

// ===== cbtg_pkg.sv
// shared constants and types for the balance timeout guard
package cbtg_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_BAL_CFG = 8'h0b;
   localparam logic [7:0] ADDR_ACQ_CFG = 8'h0c;

   // ==========================================================
   // field layout
   localparam int ACQ_LOW_LSB = 0;
   localparam int ACQ_COUNT_LSB = 8;
   localparam int ACQ_PRESCALE_LSB = 12;
   localparam int STATUS_RST_BIT = 0;
   localparam int STATUS_THERM_BIT = 1;
   localparam int NUM_SWITCHES = 12;

   // ==========================================================
   // prescale encodings and tick multiples
   localparam logic [1:0] PRESCALE_OFF = 2'h0;
   localparam logic [1:0] PRESCALE_1S = 2'h1;
   localparam logic [1:0] PRESCALE_4S = 2'h2;
   localparam logic [1:0] PRESCALE_16S = 2'h3;
   localparam logic [4:0] TICKS_1S = 5'h01;
   localparam logic [4:0] TICKS_4S = 5'h04;
   localparam logic [4:0] TICKS_16S = 5'h10;

   // ==========================================================
   // reset values
   localparam logic [1:0] PRESCALE_RST = PRESCALE_OFF;
   localparam logic [3:0] COUNT_RST = 4'h0;
   localparam logic [7:0] ACQ_LOW_RST = 8'h00;
   localparam logic [11:0] BAL_CFG_RST = 12'h000;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   // ==========================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_MHZ * 1000000;
   localparam int WAKE_DELAY_US = 280;
   localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      WAKE_OSC = 3'b001,
      WAKE_DELAY = 3'b010,
      WAKE_ACTIVE = 3'b100
   } cbtg_wake_t;

   typedef struct packed {
      logic wr;
      logic capture;
      logic [7:0] addr;
      logic [15:0] wdata;
   } cbtg_req_t;

   typedef struct packed {
      logic [31:0] base;
      logic [4:0] sub;
      logic tick;
   } cbtg_tick_state_t;

   typedef struct packed {
      cbtg_wake_t wake;
      logic [31:0] wake_cnt;
      logic rst_flag;
      logic reg_on;
      logic timeout;
      logic [3:0] count;
      logic [1:0] prescale;
      logic [7:0] acq_low;
      logic [11:0] bal_cfg;
      logic [11:0] sw_en;
      logic [15:0] rdata;
   } cbtg_state_t;

endpackage

// ===== cbtg_tick.sv
// prescaled tick generator for the balance timer
`timescale 1ns/1ps
module cbtg_tick #(
   parameter int SEC_CYCLES = cbtg_pkg::TICK_CYCLES
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic restart_i,
   input wire logic [1:0] prescale_i,
   output logic tick_o
);
   import cbtg_pkg::*;

   cbtg_tick_state_t st;
   cbtg_tick_state_t next_st;
   logic [4:0] limit;

   // ==========================================================
   // divider
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      case (prescale_i)
         PRESCALE_1S: limit = TICKS_1S;
         PRESCALE_4S: limit = TICKS_4S;
         PRESCALE_16S: limit = TICKS_16S;
         default: limit = TICKS_1S;
      endcase
      if (restart_i || prescale_i == PRESCALE_OFF) begin
         next_st.base = 32'h0;
         next_st.sub = 5'h00;
      end else if (st.base == 32'(SEC_CYCLES - 1)) begin
         next_st.base = 32'h0;
         if (st.sub == limit - 5'h01) begin
            next_st.sub = 5'h00;
            next_st.tick = 1'b1;
         end else begin
            next_st.sub = st.sub + 5'h01;
         end
      end else begin
         next_st.base = st.base + 32'h1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;

   // ==========================================================
   // checks
   property p_tick_enabled;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && tick_o |-> $past(prescale_i) != PRESCALE_OFF;
   endproperty
   a_tick_enabled: assert property (p_tick_enabled)
      else $error("tick while prescale off");

   property p_tick_single;
      @(posedge clock_i) disable iff (!arst_n_i)
      ce_i && tick_o |=> !tick_o;
   endproperty
   a_tick_single: assert property (p_tick_single)
      else $error("tick longer than one cycle");

endmodule
